// [design/ext_port_consts.svh]
// Constants for the external memory port pin block
`ifndef EXT_PORT_CONSTS_SVH
`define EXT_PORT_CONSTS_SVH
`define ADDR_W         24
`define DATA_W         16
`define BANKS          4
`define FLAG_PINS      4
`define PAR_LO         8
`define PAR_HI         15
`define SDRAM_ADDR_BIT10_BIT      10
`define WAIT_MIN       5'h02
`define ONES16         16'hffff
`define ALL_BANKS_OFF  4'hf
`define CMD_NOP        3'h7
`define CMD_ACTIVE     3'h3
`define CMD_READ       3'h5
`define CMD_WRITE      3'h4
`define CMD_REFRESH    3'h1
`define CMD_PRECHARGE  3'h2
`endif

// [design/ext_port_pkg.sv]
// Types for the external memory port pin block
package ext_port_pkg;
  typedef enum logic [1:0] {
    KIND_ASYNC_RD,
    KIND_ASYNC_WR,
    KIND_SDRAM,
    KIND_REFRESH
  } kind_t;

  // One external access request from the core side
  typedef struct packed {
    kind_t        kind;
    logic [23:0]  addr;
    logic [15:0]  wdata;
    logic [1:0]   bank;
    logic         sdWrite;
  } req_t;

  // SDRAM command pins, all active low: row, column, write
  typedef struct packed {
    logic rowN;
    logic colN;
    logic weN;
  } sdcmd_t;
endpackage

// [design/external_memory_port_pins.sv]
// External memory port pin logic: address, data, strobes, selects, SDRAM commands
`timescale 1ns/1ps
`include "ext_port_consts.svh"
`default_nettype none
module external_memory_port_pins #(
  parameter logic [4:0] WAIT_CYCLES = `WAIT_MIN
) (
  // Clock and reset
  input  wire logic                    mclk,
  input  wire logic                    rst_n,
  // Core request side
  input  wire logic                    reqValid,
  input  wire ext_port_pkg::req_t      req,
  output logic                         reqReady,
  output logic                         doneStrobe,
  output logic [`DATA_W-1:0]           rdData,
  // Pin mode controls
  input  wire logic                    parallel_input_control,
  input  wire logic [`DATA_W-1:0]      flagSelect,
  input  wire logic [`DATA_W-1:0]      flagOut,
  input  wire logic [`DATA_W-1:0]      flagDirOut,
  output logic [`DATA_W-1:0]           flagIn,
  output logic [`PAR_HI-`PAR_LO:0]     parallel_input_port,
  output logic                         parValid,
  // External memory pins
  output logic [`ADDR_W-1:0]           addrOut,
  input  wire logic [`DATA_W-1:0]      dataIn,
  output logic [`DATA_W-1:0]           dataOut,
  output logic [`DATA_W-1:0]           dataOe_n,
  input  wire logic                    ackIn,
  output logic                         rdStrobe_n,
  output logic                         wrStrobe_n,
  output logic [`BANKS-1:0]            bank_select_n,
  output logic                         sdram_row_strobe_n,
  output logic                         sdram_column_strobe_n,
  output logic                         sdram_write_strobe_n,
  output logic                         sdram_addr_bit10
);

  // ------------------------------------------------------------
  // Input synchronisers
  // ------------------------------------------------------------
  logic [`DATA_W-1:0] dataMeta_r, dataSync_r;
  logic               ackMeta_r, ackSync_r;
  always_ff @(posedge mclk) begin
    dataMeta_r <= dataIn;
    dataSync_r <= dataMeta_r;
    ackMeta_r  <= ackIn;
    ackSync_r  <= ackMeta_r;
  end

  // ------------------------------------------------------------
  // Access sequencer
  // ------------------------------------------------------------
  typedef enum logic [1:0] {ST_IDLE, ST_SETUP, ST_STROBE, ST_HOLD} state_t;

  function automatic logic [`BANKS-1:0] bankDecode(input logic [1:0] b);
    bankDecode = `ALL_BANKS_OFF;
    bankDecode[b] = 1'b0;
  endfunction

  state_t              state_r, state_nxt;
  ext_port_pkg::req_t  cur_r, cur_nxt;
  logic [4:0]          waitCnt_r, waitCnt_nxt;
  logic [`ADDR_W-1:0]  addr_r, addr_nxt;
  logic [`BANKS-1:0]   bank_r, bank_nxt;
  logic                rd_r, rd_nxt, wr_r, wr_nxt, drive_r, drive_nxt;
  ext_port_pkg::sdcmd_t cmd_r, cmd_nxt;
  logic                a10_r, a10_nxt;
  logic                done_r, done_nxt, ready_r, ready_nxt;
  logic [`DATA_W-1:0]  rdData_r, rdData_nxt;

  always_comb begin
    state_nxt  = state_r;
    cur_nxt    = cur_r;
    waitCnt_nxt = waitCnt_r;
    addr_nxt   = addr_r;
    bank_nxt   = bank_r;
    rd_nxt     = 1'b1;
    wr_nxt     = 1'b1;
    drive_nxt  = drive_r;
    cmd_nxt    = `CMD_NOP;
    a10_nxt    = a10_r;
    done_nxt   = 1'b0;
    ready_nxt  = 1'b0;
    rdData_nxt = rdData_r;
    case (state_r)
      ST_IDLE: begin
        bank_nxt  = `ALL_BANKS_OFF;
        drive_nxt = 1'b0;
        ready_nxt = 1'b1;
        if (reqValid && ready_r) begin
          cur_nxt   = req;
          addr_nxt  = req.addr;
          ready_nxt = 1'b0;
          state_nxt = ST_SETUP;
          if (req.kind != ext_port_pkg::KIND_REFRESH) begin
            bank_nxt = bankDecode(req.bank);
          end
          if (req.kind == ext_port_pkg::KIND_SDRAM ||
              req.kind == ext_port_pkg::KIND_REFRESH) begin
            a10_nxt = req.addr[`SDRAM_ADDR_BIT10_BIT];
            cmd_nxt = (req.kind == ext_port_pkg::KIND_REFRESH) ?
                      `CMD_REFRESH : `CMD_ACTIVE;
          end
        end
      end
      ST_SETUP: begin
        waitCnt_nxt = WAIT_CYCLES;
        state_nxt   = ST_STROBE;
        drive_nxt   = (cur_r.kind == ext_port_pkg::KIND_ASYNC_WR) ||
                      (cur_r.kind == ext_port_pkg::KIND_SDRAM && cur_r.sdWrite);
        if (cur_r.kind == ext_port_pkg::KIND_SDRAM) begin
          cmd_nxt = cur_r.sdWrite ? `CMD_WRITE : `CMD_READ;
        end
      end
      ST_STROBE: begin
        rd_nxt = !(cur_r.kind == ext_port_pkg::KIND_ASYNC_RD);
        wr_nxt = !(cur_r.kind == ext_port_pkg::KIND_ASYNC_WR);
        if (waitCnt_r != 5'h00) begin
          waitCnt_nxt = waitCnt_r - 5'h01;
        end else if (ackSync_r) begin
          rd_nxt     = 1'b1;
          wr_nxt     = 1'b1;
          rdData_nxt = dataSync_r;
          state_nxt  = ST_HOLD;
        end
      end
      ST_HOLD: begin
        done_nxt  = 1'b1;
        bank_nxt  = `ALL_BANKS_OFF;
        a10_nxt   = 1'b1;
        drive_nxt = 1'b0;
        if (cur_r.kind == ext_port_pkg::KIND_SDRAM) begin
          cmd_nxt = `CMD_PRECHARGE;
        end
        state_nxt = ST_IDLE;
      end
      default: state_nxt = ST_IDLE;
    endcase
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      state_r   <= ST_IDLE;
      cur_r     <= '0;
      waitCnt_r <= 5'h00;
      addr_r    <= '0;
      bank_r    <= `ALL_BANKS_OFF;
      rd_r      <= 1'b1;
      wr_r      <= 1'b1;
      drive_r   <= 1'b0;
      cmd_r     <= `CMD_NOP;
      a10_r     <= 1'b1;
      done_r    <= 1'b0;
      ready_r   <= 1'b0;
      rdData_r  <= '0;
    end else begin
      state_r   <= state_nxt;
      cur_r     <= cur_nxt;
      waitCnt_r <= waitCnt_nxt;
      addr_r    <= addr_nxt;
      bank_r    <= bank_nxt;
      rd_r      <= rd_nxt;
      wr_r      <= wr_nxt;
      drive_r   <= drive_nxt;
      cmd_r     <= cmd_nxt;
      a10_r     <= a10_nxt;
      done_r    <= done_nxt;
      ready_r   <= ready_nxt;
      rdData_r  <= rdData_nxt;
    end
  end

  // ------------------------------------------------------------
  // Data pin function mux
  // ------------------------------------------------------------
  // Flag mode wins per pin over access data; parallel input forces the upper byte to input, flag pins included
  logic [`DATA_W-1:0] dOut_r, dOut_nxt, dOe_r, dOe_nxt, fIn_r, fIn_nxt;
  logic [`PAR_HI-`PAR_LO:0] par_r, par_nxt;
  logic parV_r, parV_nxt;

  always_comb begin
    dOut_nxt = cur_r.wdata;
    dOe_nxt  = drive_nxt ? '0 : `ONES16;
    fIn_nxt  = dataSync_r & flagSelect;
    par_nxt  = par_r;
    parV_nxt = 1'b0;
    for (int i = 0; i < `DATA_W; i++) begin
      if (flagSelect[i]) begin
        dOut_nxt[i] = flagOut[i];
        dOe_nxt[i]  = !flagDirOut[i];
      end
    end
    if (parallel_input_control) begin
      dOe_nxt[`PAR_HI:`PAR_LO] = '1;
      par_nxt  = dataSync_r[`PAR_HI:`PAR_LO];
      parV_nxt = 1'b1;
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      dOut_r <= '0;
      dOe_r  <= `ONES16;
      fIn_r  <= '0;
      par_r  <= '0;
      parV_r <= 1'b0;
    end else begin
      dOut_r <= dOut_nxt;
      dOe_r  <= dOe_nxt;
      fIn_r  <= fIn_nxt;
      par_r  <= par_nxt;
      parV_r <= parV_nxt;
    end
  end

  assign reqReady              = ready_r;
  assign doneStrobe            = done_r;
  assign rdData                = rdData_r;
  assign flagIn                = fIn_r;
  assign parallel_input_port   = par_r;
  assign parValid              = parV_r;
  assign addrOut               = addr_r;
  assign dataOut               = dOut_r;
  assign dataOe_n              = dOe_r;
  assign rdStrobe_n            = rd_r;
  assign wrStrobe_n            = wr_r;
  assign bank_select_n         = bank_r;
  assign sdram_row_strobe_n    = cmd_r.rowN;
  assign sdram_column_strobe_n = cmd_r.colN;
  assign sdram_write_strobe_n  = cmd_r.weN;
  assign sdram_addr_bit10      = a10_r;

  // ------------------------------------------------------------
  // Assertions
  // ------------------------------------------------------------
  sequence s_strobe;
    state_r == ST_STROBE && waitCnt_r == 5'h00;
  endsequence
  property p_ack_hold;
    @(posedge mclk) disable iff (!rst_n)
      s_strobe ##0 !ackSync_r |=> state_r == ST_STROBE;
  endproperty
  a_ack_hold: assert property (p_ack_hold) else $error("Access ended with ack low");
  property p_rd_strobe;
    @(posedge mclk) disable iff (!rst_n)
      state_r == ST_STROBE && $past(state_r) == ST_STROBE &&
      cur_r.kind == ext_port_pkg::KIND_ASYNC_RD |-> !rdStrobe_n;
  endproperty
  a_rd_strobe: assert property (p_rd_strobe) else $error("Read strobe missing");
  property p_wr_strobe;
    @(posedge mclk) disable iff (!rst_n)
      state_r == ST_SETUP && cur_r.kind == ext_port_pkg::KIND_ASYNC_WR |=> ##1 !wrStrobe_n;
  endproperty
  a_wr_strobe: assert property (p_wr_strobe) else $error("Write strobe missing");
  property p_idle_banks;
    @(posedge mclk) disable iff (!rst_n)
      state_r == ST_IDLE && $past(state_r) == ST_IDLE |-> bank_select_n == `ALL_BANKS_OFF;
  endproperty
  a_idle_banks: assert property (p_idle_banks) else $error("Bank select active when idle");
  property p_a10;
    @(posedge mclk) disable iff (!rst_n)
      state_r == ST_SETUP && cur_r.kind == ext_port_pkg::KIND_SDRAM
      |-> sdram_addr_bit10 == addrOut[`SDRAM_ADDR_BIT10_BIT];
  endproperty
  a_a10: assert property (p_a10) else $error("SDRAM bit 10 mismatch");
  property p_reset_high;
    @(posedge mclk) !rst_n |=> rdStrobe_n && wrStrobe_n && sdram_row_strobe_n &&
      sdram_column_strobe_n && sdram_write_strobe_n;
  endproperty
  a_reset_high: assert property (p_reset_high) else $error("Strobe low after reset");
  property p_par;
    @(posedge mclk) disable iff (!rst_n)
      parallel_input_control |=> dataOe_n[`PAR_HI:`PAR_LO] == 8'hff;
  endproperty
  a_par: assert property (p_par) else $error("Parallel byte driven");
  property p_addr;
    @(posedge mclk) disable iff (!rst_n)
      reqValid && reqReady |=> addrOut == $past(req.addr);
  endproperty
  a_addr: assert property (p_addr) else $error("Address not presented");
endmodule
`default_nettype wire

// [sim/ext_mem_model.sv]
// Behavioural far side of the memory port: async memory, ack staller, pin resolver
`timescale 1ns/1ps
`default_nettype none
module ext_mem_model (
  // Clock
  input  wire logic        mclk,
  // Pins from the port
  input  wire logic [23:0] addr,
  input  wire logic [15:0] dataOut,
  input  wire logic [15:0] dataOe_n,
  input  wire logic        rdStrobe_n,
  input  wire logic        wrStrobe_n,
  input  wire logic [3:0]  bankSel_n,
  // Bench controls
  input  wire logic [7:0]  stall,
  input  wire logic [15:0] extVal,
  // Pins back to the port
  output logic [15:0]      dataIn,
  output logic             ackIn
);
  logic [15:0] mem [16];
  logic [15:0] farVal;
  logic        access;
  int          holdCnt = 0;
  logic        busyR   = 1'b0;
  // Released bus floats to the pull-up level held in extVal
  always_comb farVal = !rdStrobe_n ? mem[addr[3:0]] : extVal;
  // Port wins on pins it drives
  always_comb dataIn = (~dataOe_n & dataOut) | (dataOe_n & farVal);
  // Select decode pulls ack low at once, so it clears the port's ack synchroniser in time
  always_comb access = (bankSel_n != 4'hf);
  always_comb ackIn = !(access && (busyR ? (holdCnt != 0) : (stall != 8'h00)));
  always @(posedge mclk) begin
    if (!wrStrobe_n)
      mem[addr[3:0]] <= dataOut;
    if (access && !busyR)
      holdCnt <= stall;
    else if (holdCnt > 0)
      holdCnt <= holdCnt - 1;
    busyR <= access;
  end
endmodule
`default_nettype wire

// [sim/tb_external_memory_port_pins.sv]
// Self-checking bench for the external memory port pin block
`timescale 1ns/1ps
`include "ext_port_consts.svh"
`default_nettype none
module tb_external_memory_port_pins;
  logic mclk = 1'b0, rst_n = 1'b0, reqValid = 1'b0, parallel_input_control = 1'b0;
  ext_port_pkg::req_t req = '0;
  logic [15:0] flagSelect = '0, flagOut = '0, flagDirOut = '0, extVal = 16'hffff;
  logic [7:0] stall = '0;
  logic reqReady, doneStrobe, parValid, ackIn, rdStrobe_n, wrStrobe_n, sdram_addr_bit10;
  logic sdram_row_strobe_n, sdram_column_strobe_n, sdram_write_strobe_n;
  logic [15:0] rdData, flagIn, dataIn, dataOut, dataOe_n;
  logic [15:0] drvSeen;
  logic [7:0] parallel_input_port, cmds;
  logic [23:0] addrOut;
  logic [3:0] bank_select_n, bankSeen;
  logic seenRd, seenWr, a10Act;
  int n_errors = 0, comparisons = 0, cycles = 0, n;

  external_memory_port_pins i_external_memory_port_pins (.mclk, .rst_n, .reqValid, .req,
    .reqReady, .doneStrobe, .rdData, .parallel_input_control, .flagSelect, .flagOut,
    .flagDirOut, .flagIn, .parallel_input_port, .parValid, .addrOut, .dataIn, .dataOut,
    .dataOe_n, .ackIn, .rdStrobe_n, .wrStrobe_n, .bank_select_n, .sdram_row_strobe_n,
    .sdram_column_strobe_n, .sdram_write_strobe_n, .sdram_addr_bit10);
  ext_mem_model i_ext_mem_model (.mclk, .addr(addrOut), .dataOut, .dataOe_n, .rdStrobe_n,
    .wrStrobe_n, .bankSel_n(bank_select_n), .stall, .extVal, .dataIn, .ackIn);

  always #12.5 mclk = ~mclk;
  // Whole run needs under a hundred cycles
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 2000) begin
      n_errors++;
      finish_test();
    end
  end

  // ----
  // Shared tasks
  // ----
  task automatic chk(input string what, input logic [23:0] exp, input logic [23:0] got);
    comparisons++;
    if (got !== exp) begin
      n_errors++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic chkMin(input string what, input int least, input int got);
    comparisons++;
    if (got < least) begin
      n_errors++;
      $display("wrong value %s expected at least %0d seen %0d", what, least, got);
    end
  endtask
  task automatic finish_test();
    $display("comparisons %0d mismatches %0d", comparisons, n_errors);
    if (n_errors == 0 && comparisons > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  // One access; records what the pins showed until done
  task automatic acc(input ext_port_pkg::kind_t k, input logic [23:0] a,
                     input logic [15:0] w, input logic sdw);
    req = '{kind: k, addr: a, wdata: w, bank: 2'h1, sdWrite: sdw};
    reqValid = 1'b1;
    while (reqReady !== 1'b1) @(negedge mclk);
    @(negedge mclk);
    reqValid = 1'b0;
    {seenRd, seenWr, a10Act, bankSeen, cmds} = '0;
    drvSeen = '0;
    n = 0;
    // Done cycle is recorded too: the closing command stands there
    forever begin
      seenRd |= !rdStrobe_n;
      drvSeen |= ~dataOe_n;
      seenWr |= !wrStrobe_n;
      bankSeen |= ~bank_select_n;
      cmds[{sdram_row_strobe_n, sdram_column_strobe_n, sdram_write_strobe_n}] = 1'b1;
      if ({sdram_row_strobe_n, sdram_column_strobe_n, sdram_write_strobe_n} == `CMD_ACTIVE)
        a10Act = sdram_addr_bit10;
      if (doneStrobe === 1'b1)
        break;
      @(negedge mclk);
      n++;
    end
  endtask

  // ----
  // Scenarios
  // ----
  task automatic t_idle();
    chk("idlePins", 24'h3ff, {rdStrobe_n, wrStrobe_n, sdram_row_strobe_n,
        sdram_column_strobe_n, sdram_write_strobe_n, sdram_addr_bit10, bank_select_n});
    chk("dataOe_n", 24'hffff, dataOe_n);
    $display("test idle done");
  endtask
  task automatic t_write_read();
    acc(ext_port_pkg::KIND_ASYNC_WR, 24'h5a_3c03, 16'hc3a5, 1'b0);
    chk("addrOut", 24'h5a_3c03, addrOut);
    chk("wrSeen", 24'h1, {seenRd, seenWr});
    chk("bankSeen", 24'h2, bankSeen);
    chk("dataOut", 24'hc3a5, dataOut);
    chk("dataDrive", 24'hffff, drvSeen);
    repeat (2) @(negedge mclk);
    chk("bankIdle", 24'hf, bank_select_n);
    // Slow partner: ack held low eleven cycles
    stall = 8'h0a;
    acc(ext_port_pkg::KIND_ASYNC_RD, 24'h5a_3c03, 16'h0000, 1'b0);
    stall = 8'h00;
    chk("rdData", 24'hc3a5, rdData);
    chk("rdSeen", 24'h2, {seenRd, seenWr});
    chk("dataRelease", 24'h0, drvSeen);
    chkMin("waitLen", 13, n);
    $display("test write read done");
  endtask
  task automatic t_sdram();
    // Bits: precharge 2, active 3, write 4, read 5, refresh 1
    for (int i = 0; i < 2; i++) begin
      acc(ext_port_pkg::KIND_SDRAM, i ? 24'h00_0800 : 24'h00_0400, 16'h1234, i[0]);
      chk("sdCmds", i ? 24'h1c : 24'h2c, cmds & (i ? 8'h1c : 8'h2c));
      chk("a10", i ? 24'h0 : 24'h1, a10Act);
    end
    acc(ext_port_pkg::KIND_REFRESH, 24'h00_0000, 16'h0000, 1'b0);
    chk("refCmd", 24'h2, cmds & 8'h02);
    chk("refBanks", 24'h0, bankSeen);
    $display("test sdram done");
  endtask
  task automatic t_pins();
    flagSelect = 16'h000f;
    flagDirOut = 16'h0001;
    flagOut = 16'h0001;
    parallel_input_control = 1'b1;
    extVal = 16'h5a3c;
    repeat (5) @(negedge mclk);
    chk("flagIn", 24'h000d, flagIn);
    chk("flagDrive", 24'h0, dataOe_n[0]);
    chk("parPort", 24'h5a, parallel_input_port);
    chk("parValid", 24'h1, parValid);
    $display("test pins done");
  endtask

  initial begin
    repeat (2) @(negedge mclk);
    t_idle();
    @(negedge mclk);
    rst_n = 1'b1;
    @(negedge mclk);
    t_idle();
    t_write_read();
    t_sdram();
    t_pins();
    finish_test();
  end
endmodule
`default_nettype wire
